// File: core/dlc_decode.sv
// Field decoder: coded settings to scaled values
`timescale 1ns/100ps
`include "dlc_defines.svh"
module dlc_decode
  import dlc_pkg::*;
(
  input  wire logic [31:0] i_brake,
  input  wire logic [31:0] i_gains,
  input  wire logic [31:0] i_power,
  output logic [7:0]       o_win_pct,
  output logic [9:0]       o_thr_pct,
  output logic [10:0]      o_floor_mv,
  output logic [10:0]      o_ceil_mv,
  output logic [5:0]       o_exit_pct,
  output logic [9:0]       o_oceil_pct,
  output logic [7:0]       o_ofloor_pct,
  output logic [6:0]       o_hyst_pct,
  output logic             o_bad_code
);
  // ----------------------------------------------------------------
  // Lookup functions, percentages in tenths
  // ----------------------------------------------------------------
  function automatic logic [7:0] pct_low(input logic [2:0] c);
    case (c)
      3'h0:    pct_low = 8'd0;
      3'h1:    pct_low = 8'd25;
      3'h2:    pct_low = 8'd50;
      3'h3:    pct_low = 8'd75;
      3'h4:    pct_low = 8'd100;
      3'h5:    pct_low = 8'd150;
      3'h6:    pct_low = 8'd200;
      default: pct_low = 8'd250;
    endcase
  endfunction : pct_low

  function automatic logic [9:0] pct_high(input logic [2:0] c);
    pct_high = 10'd1000 - 10'd50 * {7'h0, c};
  endfunction : pct_high

  // Code 0 is reserved and decodes to 0 mV
  function automatic logic [10:0] sense_mv(input logic [3:0] c);
    sense_mv = 11'd100 * {7'h0, c};
  endfunction : sense_mv

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  always_comb
  begin
    o_win_pct    = pct_low(i_brake[`DLC_WIN_MSB:`DLC_WIN_LSB]);
    o_thr_pct    = pct_high(i_brake[`DLC_THR_MSB:`DLC_THR_LSB]);
    o_floor_mv   = sense_mv(i_brake[`DLC_FLOOR_MSB:`DLC_FLOOR_LSB]);
    o_ceil_mv    = sense_mv(i_brake[`DLC_CEIL_MSB:`DLC_CEIL_LSB]);
    o_oceil_pct  = pct_high(i_gains[`DLC_OCEIL_MSB:`DLC_OCEIL_LSB]);
    o_ofloor_pct = pct_low(i_gains[`DLC_OFLOOR_MSB:`DLC_OFLOOR_LSB]);
    case (i_brake[`DLC_EXIT_MSB:`DLC_EXIT_LSB])
      3'h6:    o_exit_pct = 6'd40;
      3'h7:    o_exit_pct = 6'd50;
      default: o_exit_pct = 6'd5 * {3'h0, i_brake[`DLC_EXIT_MSB:`DLC_EXIT_LSB]} + 6'd5;
    endcase
    o_hyst_pct = 7'd25 * {5'h0, i_power[`DLC_HYST_MSB:`DLC_HYST_LSB]} + 7'd50;
    // Reserved codes flagged so firmware slips are visible
    o_bad_code = (i_brake[`DLC_FLOOR_MSB:`DLC_FLOOR_LSB] == 4'h0)
               || (i_brake[`DLC_CEIL_MSB:`DLC_CEIL_LSB] == 4'h0)
               || (i_gains[`DLC_LOOP_MSB:`DLC_LOOP_LSB] == DLC_LOOP_RSVD)
               || (i_power[`DLC_PMODE_MSB:`DLC_PMODE_LSB] == DLC_PWR_RSVD);
  end
endmodule : dlc_decode

// File: core/dlc_defines.svh
// Offsets, field positions and reset values of the braking and loop config bank
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
`ifndef DLC_DEFINES_SVH
`define DLC_DEFINES_SVH
`define DLC_OFS_BRAKE     8'h8c
`define DLC_OFS_GAINS     8'h8e
`define DLC_OFS_POWER     8'h90
`define DLC_RST_VAL       32'h00000000
`define DLC_PARITY_BIT    31
`define DLC_MASK_BIT      19
`define DLC_WIN_MSB       18
`define DLC_WIN_LSB       16
`define DLC_THR_MSB       15
`define DLC_THR_LSB       13
`define DLC_FLOOR_MSB     12
`define DLC_FLOOR_LSB     9
`define DLC_TAPER_BIT     8
`define DLC_QUICK_BIT     7
`define DLC_CEIL_MSB      6
`define DLC_CEIL_LSB      3
`define DLC_EXIT_MSB      2
`define DLC_EXIT_LSB      0
`define DLC_KP_MSB        29
`define DLC_KP_LSB        20
`define DLC_KI_MSB        19
`define DLC_KI_LSB        8
`define DLC_OCEIL_MSB     7
`define DLC_OCEIL_LSB     5
`define DLC_OFLOOR_MSB    4
`define DLC_OFLOOR_LSB    2
`define DLC_LOOP_MSB      1
`define DLC_LOOP_LSB      0
`define DLC_SPD_MSB       30
`define DLC_SPD_LSB       15
`define DLC_DEAD_BIT      14
`define DLC_PWR_MSB       13
`define DLC_PWR_LSB       4
`define DLC_HYST_MSB      3
`define DLC_HYST_LSB      2
`define DLC_PMODE_MSB     1
`define DLC_PMODE_LSB     0
`endif

// File: core/dlc_pkg.sv
// Types shared by the braking and loop config bank
package dlc_pkg;
  // Regulation loop selector codes
  typedef enum logic [1:0] {
    DLC_LOOP_OFF   = 2'b00,
    DLC_LOOP_SPEED = 2'b01,
    DLC_LOOP_POWER = 2'b10,
    DLC_LOOP_RSVD  = 2'b11
  } dlc_loop_t;
  // Input power regulation codes
  typedef enum logic [1:0] {
    DLC_PWR_OFF    = 2'b00,
    DLC_PWR_CLOSED = 2'b01,
    DLC_PWR_LIMIT  = 2'b10,
    DLC_PWR_RSVD   = 2'b11
  } dlc_pmode_t;
endpackage : dlc_pkg

// File: core/dlc_regs.sv
// Braking and regulation loop configuration register bank
`timescale 1ns/100ps
`include "dlc_defines.svh"
module dlc_regs
  import dlc_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input  wire logic              i_clock,
  input  wire logic              i_rst,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [31:0]       i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic [31:0]            o_rdata,
  output logic                   o_comparator_mask_on,
  output logic                   o_current_limit_taper_on,
  output logic                   o_quick_braking_on,
  output logic                   o_dead_interval_correction_on,
  output logic [7:0]             o_braking_duty_window,
  output logic [9:0]             o_braking_duty_limit,
  output logic [10:0]            o_braking_current_floor,
  output logic [10:0]            o_braking_current_ceiling,
  output logic [5:0]             o_braking_exit_margin,
  output logic [9:0]             o_loop_proportional_gain,
  output logic [11:0]            o_loop_integral_gain,
  output logic [9:0]             o_loop_output_ceiling,
  output logic [7:0]             o_loop_output_floor,
  output dlc_loop_t              o_loop_mode,
  output logic [15:0]            o_max_speed,
  output logic [9:0]             o_max_power,
  output logic [6:0]             o_power_regulation_hysteresis,
  output dlc_pmode_t             o_power_mode,
  output logic                   o_bad_code
);
  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  // Offsets are eight bits wide, a narrower bus cannot reach them
  if (ADDR_W < 8)
  begin : g_chk
    $error("ADDR_W must be at least 8");
  end

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [31:0] brake;
  logic [31:0] gains;
  logic [31:0] power;
  logic        hit_brake;
  logic        hit_gains;
  logic        hit_power;

  // Upper address bits must be zero for a hit
  assign hit_brake = (i_addr == ADDR_W'(`DLC_OFS_BRAKE));
  assign hit_gains = (i_addr == ADDR_W'(`DLC_OFS_GAINS));
  assign hit_power = (i_addr == ADDR_W'(`DLC_OFS_POWER));

  // Full word write keeps parity and reserved bits as given
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      brake <= `DLC_RST_VAL;
    end
    else if (i_wr && hit_brake)
    begin
      brake <= i_wdata;
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      gains <= `DLC_RST_VAL;
    end
    else if (i_wr && hit_gains)
    begin
      gains <= i_wdata;
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      power <= `DLC_RST_VAL;
    end
    else if (i_wr && hit_power)
    begin
      power <= i_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Data stand one cycle after the strobe only; unmapped reads give zero
  always_ff @(posedge i_clock)
  begin
    if (i_rst || !i_rd)
    begin
      o_rdata <= 32'h0;
    end
    else if (hit_brake)
    begin
      o_rdata <= brake;
    end
    else if (hit_gains)
    begin
      o_rdata <= gains;
    end
    else if (hit_power)
    begin
      o_rdata <= power;
    end
    else
    begin
      o_rdata <= 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // Decoder
  // ----------------------------------------------------------------
  logic [7:0]  dec_win;
  logic [9:0]  dec_thr;
  logic [10:0] dec_floor;
  logic [10:0] dec_ceil;
  logic [5:0]  dec_exit;
  logic [9:0]  dec_oceil;
  logic [7:0]  dec_ofloor;
  logic [6:0]  dec_hyst;
  logic        dec_bad;

  dlc_decode u_decode (
    .i_brake      (brake),
    .i_gains      (gains),
    .i_power      (power),
    .o_win_pct    (dec_win),
    .o_thr_pct    (dec_thr),
    .o_floor_mv   (dec_floor),
    .o_ceil_mv    (dec_ceil),
    .o_exit_pct   (dec_exit),
    .o_oceil_pct  (dec_oceil),
    .o_ofloor_pct (dec_ofloor),
    .o_hyst_pct   (dec_hyst),
    .o_bad_code   (dec_bad)
  );

  // ----------------------------------------------------------------
  // Braking outputs
  // ----------------------------------------------------------------
  // Registered so consumers see glitch free settings, one cycle late
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      o_comparator_mask_on     <= 1'b0;
      o_current_limit_taper_on <= 1'b0;
      o_quick_braking_on       <= 1'b0;
      o_braking_duty_window    <= 8'h0;
      o_braking_duty_limit     <= 10'h0;
      o_braking_current_floor  <= 11'h0;
      o_braking_current_ceiling <= 11'h0;
      o_braking_exit_margin    <= 6'h0;
    end
    else
    begin
      o_comparator_mask_on     <= brake[`DLC_MASK_BIT];
      o_current_limit_taper_on <= brake[`DLC_TAPER_BIT];
      o_quick_braking_on       <= brake[`DLC_QUICK_BIT];
      o_braking_duty_window    <= dec_win;
      o_braking_duty_limit     <= dec_thr;
      o_braking_current_floor  <= dec_floor;
      o_braking_current_ceiling <= dec_ceil;
      o_braking_exit_margin    <= dec_exit;
    end
  end

  // ----------------------------------------------------------------
  // Loop outputs
  // ----------------------------------------------------------------
  // Gains leave raw; scaling by 1e4 and 1e6 belongs to the loop math
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      o_loop_proportional_gain <= 10'h0;
      o_loop_integral_gain     <= 12'h0;
      o_loop_output_ceiling    <= 10'h0;
      o_loop_output_floor      <= 8'h0;
      o_loop_mode              <= DLC_LOOP_OFF;
    end
    else
    begin
      o_loop_proportional_gain <= gains[`DLC_KP_MSB:`DLC_KP_LSB];
      o_loop_integral_gain     <= gains[`DLC_KI_MSB:`DLC_KI_LSB];
      o_loop_output_ceiling    <= dec_oceil;
      o_loop_output_floor      <= dec_ofloor;
      o_loop_mode              <= dlc_loop_t'(gains[`DLC_LOOP_MSB:`DLC_LOOP_LSB]);
    end
  end

  // ----------------------------------------------------------------
  // Power outputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      o_dead_interval_correction_on <= 1'b0;
      o_max_speed                   <= 16'h0;
      o_max_power                   <= 10'h0;
      o_power_regulation_hysteresis <= 7'h0;
      o_power_mode                  <= DLC_PWR_OFF;
      o_bad_code                    <= 1'b0;
    end
    else
    begin
      o_dead_interval_correction_on <= power[`DLC_DEAD_BIT];
      o_max_speed                   <= power[`DLC_SPD_MSB:`DLC_SPD_LSB];
      o_max_power                   <= power[`DLC_PWR_MSB:`DLC_PWR_LSB];
      o_power_regulation_hysteresis <= dec_hyst;
      o_power_mode                  <= dlc_pmode_t'(power[`DLC_PMODE_MSB:`DLC_PMODE_LSB]);
      o_bad_code                    <= dec_bad;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  property p_rst_zero;
    $past(i_rst) |-> (brake == 32'h0) && (gains == 32'h0) && (power == 32'h0);
  endproperty
  a_rst_zero: assert property (p_rst_zero) else $error("bank not zero after reset");

  property p_mask;
    i_wr && hit_brake ##1 !i_wr |=> o_comparator_mask_on == $past(brake[19]);
  endproperty
  a_mask: assert property (p_mask) else $error("mask bit not followed");

  property p_win;
    brake[18:16] == 3'h5 |=> o_braking_duty_window == 8'd150;
  endproperty
  a_win: assert property (p_win) else $error("duty window code 5 wrong");

  property p_thr;
    brake[15:13] == 3'h7 |=> o_braking_duty_limit == 10'd650;
  endproperty
  a_thr: assert property (p_thr) else $error("duty limit code 7 wrong");

  property p_floor;
    brake[12:9] == 4'hf |=> o_braking_current_floor == 11'd1500;
  endproperty
  a_floor: assert property (p_floor) else $error("current floor code f wrong");

  property p_taper;
    i_wr && hit_brake ##1 1'b1 |=> o_current_limit_taper_on == $past(i_wdata[8], 2);
  endproperty
  a_taper: assert property (p_taper) else $error("taper bit not followed");

  property p_quick;
    $rose(brake[7]) |=> o_quick_braking_on;
  endproperty
  a_quick: assert property (p_quick) else $error("quick braking not on");

  property p_ceil;
    brake[6:3] == 4'h1 |=> o_braking_current_ceiling == 11'd100;
  endproperty
  a_ceil: assert property (p_ceil) else $error("current ceiling code 1 wrong");

  property p_exit;
    brake[2:0] == 3'h6 |=> o_braking_exit_margin == 6'd40;
  endproperty
  a_exit: assert property (p_exit) else $error("exit margin code 6 wrong");

  property p_kp;
    i_wr && hit_gains ##2 1'b1 |-> o_loop_proportional_gain == $past(i_wdata[29:20], 2);
  endproperty
  a_kp: assert property (p_kp) else $error("proportional gain lost");

  property p_ki;
    i_wr && hit_gains ##2 1'b1 |-> o_loop_integral_gain == $past(i_wdata[19:8], 2);
  endproperty
  a_ki: assert property (p_ki) else $error("integral gain lost");

  property p_oceil;
    gains[7:5] == 3'h2 |=> o_loop_output_ceiling == 10'd900;
  endproperty
  a_oceil: assert property (p_oceil) else $error("output ceiling code 2 wrong");

  property p_ofloor;
    gains[4:2] == 3'h3 |=> o_loop_output_floor == 8'd75;
  endproperty
  a_ofloor: assert property (p_ofloor) else $error("output floor code 3 wrong");

  property p_loop;
    gains[1:0] == 2'h1 |=> o_loop_mode == DLC_LOOP_SPEED;
  endproperty
  a_loop: assert property (p_loop) else $error("speed loop not selected");

  property p_speed;
    i_wr && hit_power ##2 1'b1 |-> o_max_speed == $past(i_wdata[30:15], 2);
  endproperty
  a_speed: assert property (p_speed) else $error("max speed lost");

  property p_dead;
    $fell(power[14]) |=> !o_dead_interval_correction_on;
  endproperty
  a_dead: assert property (p_dead) else $error("dead interval correction stuck");

  // Every stored max power value reaches the output one edge later, not just one code
  property p_pwr;
    !$past(i_rst) |-> o_max_power == $past(power[13:4]);
  endproperty
  a_pwr: assert property (p_pwr) else $error("max power wrong");

  property p_hyst;
    power[3:2] == 2'h3 |=> o_power_regulation_hysteresis == 7'd125;
  endproperty
  a_hyst: assert property (p_hyst) else $error("hysteresis code 3 wrong");

  property p_pmode;
    power[1:0] == 2'h3 |=> o_power_mode == DLC_PWR_RSVD && o_bad_code;
  endproperty
  a_pmode: assert property (p_pmode) else $error("reserved power mode not flagged");

  property p_parity;
    i_wr && hit_gains ##1 i_rd && hit_gains |=> o_rdata[31] == $past(i_wdata[31], 2);
  endproperty
  a_parity: assert property (p_parity) else $error("parity bit not returned");

  property p_rsvd;
    i_wr && hit_brake ##1 i_rd && hit_brake |=> o_rdata[30:20] == $past(i_wdata[30:20], 2);
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits not kept");

  property p_rd_one;
    !i_rd |=> o_rdata == 32'h0;
  endproperty
  a_rd_one: assert property (p_rd_one) else $error("read data held too long");

  c_quick_on: cover property (i_wr && hit_brake && i_wdata[7]);
  c_speed_loop: cover property (o_loop_mode == DLC_LOOP_SPEED && o_loop_integral_gain != 12'h0);
  c_power_limit: cover property (o_power_mode == DLC_PWR_LIMIT);
  c_wr_rd: cover property (i_wr && hit_power ##1 i_rd && hit_power);
endmodule : dlc_regs

// File: tb/dlc_regs_test.sv
// Self-checking bench for the braking and loop configuration register bank
`timescale 1ns/100ps
`include "dlc_defines.svh"

// ----------------------------------------------------------------------------
// Comparison helper
// ----------------------------------------------------------------------------
`define DLC_CHECK(act, exp) \
  begin \
    cmp_count++; \
    if ((act) !== (exp)) \
    begin \
      error_cnt++; \
      $display("unexpected at %0t: got %0h expected %0h", $time, (act), (exp)); \
    end \
  end

module dlc_regs_test
  import dlc_pkg::*;
;
  logic        i_clock;
  logic        i_rst;
  logic [7:0]  i_addr;
  logic [31:0] i_wdata;
  logic        i_wr;
  logic        i_rd;
  logic [31:0] o_rdata;
  logic        o_comparator_mask_on;
  logic        o_current_limit_taper_on;
  logic        o_quick_braking_on;
  logic        o_dead_interval_correction_on;
  logic [7:0]  o_braking_duty_window;
  logic [9:0]  o_braking_duty_limit;
  logic [10:0] o_braking_current_floor;
  logic [10:0] o_braking_current_ceiling;
  logic [5:0]  o_braking_exit_margin;
  logic [9:0]  o_loop_proportional_gain;
  logic [11:0] o_loop_integral_gain;
  logic [9:0]  o_loop_output_ceiling;
  logic [7:0]  o_loop_output_floor;
  dlc_loop_t   o_loop_mode;
  logic [15:0] o_max_speed;
  logic [9:0]  o_max_power;
  logic [6:0]  o_power_regulation_hysteresis;
  dlc_pmode_t  o_power_mode;
  logic        o_bad_code;
  int          error_cnt;
  int          cmp_count;
  int          cyc_cnt;
  logic [31:0] sh_brake;
  logic [31:0] sh_gains;
  logic [31:0] sh_power;
  logic [7:0]  win_tab [8];
  logic [5:0]  exit_tab [8];

  dlc_regs dlc_regs_i (
    .i_clock                       (i_clock),
    .i_rst                         (i_rst),
    .i_addr                        (i_addr),
    .i_wdata                       (i_wdata),
    .i_wr                          (i_wr),
    .i_rd                          (i_rd),
    .o_rdata                       (o_rdata),
    .o_comparator_mask_on          (o_comparator_mask_on),
    .o_current_limit_taper_on      (o_current_limit_taper_on),
    .o_quick_braking_on            (o_quick_braking_on),
    .o_dead_interval_correction_on (o_dead_interval_correction_on),
    .o_braking_duty_window         (o_braking_duty_window),
    .o_braking_duty_limit          (o_braking_duty_limit),
    .o_braking_current_floor       (o_braking_current_floor),
    .o_braking_current_ceiling     (o_braking_current_ceiling),
    .o_braking_exit_margin         (o_braking_exit_margin),
    .o_loop_proportional_gain      (o_loop_proportional_gain),
    .o_loop_integral_gain          (o_loop_integral_gain),
    .o_loop_output_ceiling         (o_loop_output_ceiling),
    .o_loop_output_floor           (o_loop_output_floor),
    .o_loop_mode                   (o_loop_mode),
    .o_max_speed                   (o_max_speed),
    .o_max_power                   (o_max_power),
    .o_power_regulation_hysteresis (o_power_regulation_hysteresis),
    .o_power_mode                  (o_power_mode),
    .o_bad_code                    (o_bad_code)
  );

  // ----------------------------------------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------------------------------------
  always #2 i_clock = ~i_clock;

  // Whole run needs well under a thousand cycles; the ceiling leaves margin
  always @(posedge i_clock)
  begin
    cyc_cnt++;
    if (cyc_cnt == 5000)
    begin
      error_cnt++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------------------
  // Bus and checking tasks
  // ----------------------------------------------------------------------------
  // One-cycle write strobe; the shadow copy mirrors only mapped offsets
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr <= 1'b0;
    case (a)
      `DLC_OFS_BRAKE: sh_brake = d;
      `DLC_OFS_GAINS: sh_gains = d;
      `DLC_OFS_POWER: sh_power = d;
      default: ;
    endcase
  endtask : bus_wr

  // Read data stands one cycle only, then must fall back to zero
  task automatic bus_rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_clock);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1;
    `DLC_CHECK(o_rdata, exp)
    @(posedge i_clock);
    #1;
    `DLC_CHECK(o_rdata, 32'h0)
  endtask : bus_rd

  // Field outputs trail the write strobe edge by one edge
  task automatic settle();
    @(posedge i_clock);
    #1;
  endtask : settle

  task automatic check_all();
    logic [31:0] b;
    logic [31:0] g;
    logic [31:0] p;
    b = sh_brake;
    g = sh_gains;
    p = sh_power;
    `DLC_CHECK(o_comparator_mask_on, b[19])
    `DLC_CHECK(o_braking_duty_window, win_tab[b[18:16]])
    `DLC_CHECK(o_braking_duty_limit, 10'(1000 - 50 * b[15:13]))
    `DLC_CHECK(o_braking_current_floor, 11'(100 * b[12:9]))
    `DLC_CHECK(o_current_limit_taper_on, b[8])
    `DLC_CHECK(o_quick_braking_on, b[7])
    `DLC_CHECK(o_braking_current_ceiling, 11'(100 * b[6:3]))
    `DLC_CHECK(o_braking_exit_margin, exit_tab[b[2:0]])
    `DLC_CHECK(o_loop_proportional_gain, g[29:20])
    `DLC_CHECK(o_loop_integral_gain, g[19:8])
    `DLC_CHECK(o_loop_output_ceiling, 10'(1000 - 50 * g[7:5]))
    `DLC_CHECK(o_loop_output_floor, win_tab[g[4:2]])
    `DLC_CHECK(o_loop_mode, g[1:0])
    `DLC_CHECK(o_max_speed, p[30:15])
    `DLC_CHECK(o_dead_interval_correction_on, p[14])
    `DLC_CHECK(o_max_power, p[13:4])
    `DLC_CHECK(o_power_regulation_hysteresis, 7'(50 + 25 * p[3:2]))
    `DLC_CHECK(o_power_mode, p[1:0])
    `DLC_CHECK(o_bad_code, 1'((b[12:9] == 0) || (b[6:3] == 0) || (g[1:0] == 3) || (p[1:0] == 3)))
  endtask : check_all

  task automatic read_all();
    bus_rd(`DLC_OFS_BRAKE, sh_brake);
    bus_rd(`DLC_OFS_GAINS, sh_gains);
    bus_rd(`DLC_OFS_POWER, sh_power);
  endtask : read_all

  // Synchronous reset; stored zero floor and ceiling codes are reserved so the bad-code flag rises
  task automatic do_reset(input int cycles);
    @(posedge i_clock);
    i_rst <= 1'b1;
    repeat (cycles) @(posedge i_clock);
    #1;
    `DLC_CHECK(o_quick_braking_on, 1'b0)
    @(posedge i_clock);
    i_rst    <= 1'b0;
    sh_brake = 32'h0;
    sh_gains = 32'h0;
    sh_power = 32'h0;
    repeat (2) @(posedge i_clock);
    #1;
    check_all();
    read_all();
  endtask : do_reset

  // ----------------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------------
  // Every code of every braking field, with parity and reserved bits toggled
  task automatic t_brake();
    for (int c = 0; c < 16; c++)
    begin
      bus_wr(`DLC_OFS_BRAKE, {c[0], 11'h5a5 ^ 11'(c), c[0], c[2:0], ~c[2:0], 4'(c), c[1], c[2],
                              4'(15 - c), c[2:0]});
      settle();
      check_all();
      bus_rd(`DLC_OFS_BRAKE, sh_brake);
    end
    $display("test brake done");
  endtask : t_brake

  // Loop gains, saturation tables and all four selector codes
  task automatic t_gains();
    for (int c = 0; c < 8; c++)
    begin
      bus_wr(`DLC_OFS_GAINS, {c[0], c[1], c[2:0], 7'h2a ^ 7'(c), c[2:0], 9'h155, c[2:0], ~c[2:0], c[1:0]});
      settle();
      check_all();
      bus_rd(`DLC_OFS_GAINS, sh_gains);
    end
    $display("test gains done");
  endtask : t_gains

  // Speed and power limits, hysteresis and all four power modes
  task automatic t_power();
    for (int c = 0; c < 8; c++)
    begin
      bus_wr(`DLC_OFS_POWER, {c[0], c[2:0], 13'h1a5a, c[1], c[2:0], 7'h3c, c[1:0], c[2:1]});
      settle();
      check_all();
      bus_rd(`DLC_OFS_POWER, sh_power);
    end
    $display("test power done");
  endtask : t_power

  // Neighbouring and far offsets are not mapped: writes vanish, reads give zero
  task automatic t_unmapped();
    logic [7:0] bad [5];
    bad = '{8'h8d, 8'h8f, 8'h91, 8'h00, 8'hff};
    foreach (bad[k])
    begin
      bus_wr(bad[k], 32'hffffffff);
      bus_rd(bad[k], 32'h0);
    end
    settle();
    check_all();
    read_all();
    $display("test unmapped done");
  endtask : t_unmapped

  // Read right behind a write to the same offset must see the new word, on every offset
  task automatic t_back_to_back();
    logic [7:0]  ofs [3];
    logic [31:0] val [3];
    ofs = '{`DLC_OFS_BRAKE, `DLC_OFS_GAINS, `DLC_OFS_POWER};
    val = '{32'h9e5a_4c3b, 32'heb3c_a5d6, 32'hc3a5_5a3c};
    foreach (ofs[k])
    begin
      @(posedge i_clock);
      i_wr    <= 1'b1;
      i_addr  <= ofs[k];
      i_wdata <= val[k];
      @(posedge i_clock);
      i_wr <= 1'b0;
      i_rd <= 1'b1;
      @(posedge i_clock);
      i_rd <= 1'b0;
      #1;
      `DLC_CHECK(o_rdata, val[k])
      @(posedge i_clock);
      #1;
      `DLC_CHECK(o_rdata, 32'h0)
    end
    sh_brake = val[0];
    sh_gains = val[1];
    sh_power = val[2];
    check_all();
    $display("test back to back done");
  endtask : t_back_to_back

  // A reset in mid-run wipes every stored word
  task automatic t_mid_reset();
    bus_wr(`DLC_OFS_BRAKE, 32'hffffffff);
    bus_wr(`DLC_OFS_GAINS, 32'hffffffff);
    do_reset(2);
    $display("test mid reset done");
  endtask : t_mid_reset

  // ----------------------------------------------------------------------------
  // Main sequence and verdict
  // ----------------------------------------------------------------------------
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run

  initial
  begin
    i_clock   = 1'b0;
    i_rst     = 1'b1;
    i_addr    = 8'h00;
    i_wdata   = 32'h0;
    i_wr      = 1'b0;
    i_rd      = 1'b0;
    error_cnt = 0;
    cmp_count = 0;
    cyc_cnt   = 0;
    win_tab   = '{8'd0, 8'd25, 8'd50, 8'd75, 8'd100, 8'd150, 8'd200, 8'd250};
    exit_tab  = '{6'd5, 6'd10, 6'd15, 6'd20, 6'd25, 6'd30, 6'd40, 6'd50};
    do_reset(6);
    $display("test reset done");
    t_brake();
    t_gains();
    t_power();
    t_unmapped();
    t_back_to_back();
    t_mid_reset();
    complete_run();
  end

endmodule : dlc_regs_test
